// file: design/bsg_gain_sel.sv
// Purpose: Select one gain multiplier from pre-sync code and post-sync bit
// Assumes: Multipliers in half-base units
// Notes: Instantiated once for integral, once for proportional
`timescale 1ns/100ps
module bsg_gain_sel #(
	parameter logic [3:0] POST_VALUE = 4'h2
) (
	input wire logic [1:0] pre_code,
	input wire logic post_bit,
	input wire logic synced,
	output logic [3:0] gain
);
	// Code n selects (n+1) times base, i.e. 2(n+1) half units
	wire logic [3:0] pre_gain = {1'b0, pre_code, 1'b0} + 4'h2;
	wire logic use_post = synced & post_bit;
	assign gain = use_post ? POST_VALUE : pre_gain;
endmodule

// file: design/bsg_rate_clamp.sv
// Purpose: Clamp a signed data rate offset to a symmetric limit
// Assumes: Offset and limit share units of 1/32 percent
// Notes: Zero limit forces the offset to zero
`timescale 1ns/100ps
module bsg_rate_clamp #(
	parameter int W = 16
) (
	input wire logic signed [W-1:0] offset_in,
	input wire logic [W-1:0] limit,
	output logic signed [W-1:0] offset_out
);
	wire logic signed [W-1:0] pos_lim = $signed(limit);
	wire logic signed [W-1:0] neg_lim = -$signed(limit);
	wire logic over = offset_in > pos_lim;
	wire logic under = offset_in < neg_lim;
	assign offset_out = over ? pos_lim : (under ? neg_lim : offset_in);
endmodule

// file: design/bsg_top.sv
// Purpose: Clock recovery loop gain configuration with APB access
// Assumes: Sync detect, carrier sense and loop update strobe from demod
// Notes: Gains leave in half-base units, offset in 1/32 percent units
//
// Summary of operation
// RULE_01 - Pre-sync integral gain from bits 7:6, codes give 1..4 times base
// RULE_02 - Pre-sync proportional gain from bits 5:4, codes give 1..4 times
// RULE_03 - Post-sync integral gain: bit 3 zero keeps pre, one gives half
// RULE_04 - Post-sync proportional gain: bit 2 zero keeps pre, one gives base
// RULE_05 - Pre-sync integral term tracks the data rate offset
// RULE_06 - Accumulated rate offset clamps at limit set by bits 1:0
// RULE_07 - Limit codes: off, 3.125, 6.25, 12.5 percent
// RULE_08 - With freeze option set, loops hold until carrier sense rises
// RULE_09 - All fields read and write; new values apply at next loop update, a new limit only at one taken while not frozen
`timescale 1ns/100ps
module bsg_top #(
	parameter int OFS_W = 16
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SYNC_DETECTED,
	input wire logic CARRIER_SENSE,
	input wire logic LOOP_UPDATE,
	input wire logic signed [OFS_W-1:0] RATE_ERROR,
	output logic [3:0] INTEGRAL_GAIN,
	output logic [3:0] PROPORTIONAL_GAIN,
	output logic signed [OFS_W-1:0] RATE_OFFSET,
	output logic LOOP_FROZEN
);
	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// No wait states, so every access phase completes at once
	wire logic setup = PSEL & ~PENABLE;
	wire logic access = PSEL & PENABLE;
	wire logic hit_cfg = PADDR == bsg_pkg::ADDR_CFG;
	wire logic hit_ctrl = PADDR == bsg_pkg::ADDR_CTRL;
	wire logic hit_stat = PADDR == bsg_pkg::ADDR_STAT;
	wire logic mapped = hit_cfg | hit_ctrl | hit_stat;
	wire logic lane0 = PSTRB[0];
	wire logic wr_req = access & PWRITE & lane0;
	wire logic wr_cfg = wr_req & hit_cfg;
	wire logic wr_ctrl = wr_req & hit_ctrl;
	wire logic rd_setup = setup & ~PWRITE;
	wire logic err_setup = setup & ~mapped;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] cfg_ff;
	logic [7:0] nxt_cfg;
	logic [0:0] ctrl_ff;
	logic [0:0] nxt_ctrl;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pslverr_ff;
	logic [3:0] ki_ff;
	logic [3:0] kp_ff;
	logic signed [OFS_W-1:0] ofs_ff;
	logic frozen_ff;
	bsg_pkg::bsg_state_t state_ff;
	bsg_pkg::bsg_state_t nxt_state;

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Only byte lane 0 carries field bits; upper lanes are ignored
	assign nxt_cfg = wr_cfg ? PWDATA[7:0] : cfg_ff; // RULE_09
	assign nxt_ctrl = wr_ctrl ? PWDATA[0:0] : ctrl_ff;
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			cfg_ff <= bsg_pkg::CFG_RESET;
		else
			cfg_ff <= nxt_cfg;
	end
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			ctrl_ff <= bsg_pkg::CTRL_RESET;
		else
			ctrl_ff <= nxt_ctrl;
	end

	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	wire logic [1:0] pre_ki = cfg_ff[bsg_pkg::PRE_KI_LSB +: 2];
	wire logic [1:0] pre_kp = cfg_ff[bsg_pkg::PRE_KP_LSB +: 2];
	wire logic post_ki = cfg_ff[bsg_pkg::POST_KI_BIT];
	wire logic post_kp = cfg_ff[bsg_pkg::POST_KP_BIT];
	wire logic [1:0] lim_code = cfg_ff[bsg_pkg::LIMIT_LSB +: 2];
	wire logic freeze_en = ctrl_ff[bsg_pkg::FREEZE_BIT];

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire logic [13:0] stat_pad = 14'h0000;
	wire logic [1:0] stat_state = state_ff;
	wire logic [31:0] stat_word = {stat_pad, stat_state, ofs_ff};
	wire logic [31:0] cfg_word = {24'h000000, cfg_ff};
	wire logic [31:0] ctrl_word = {31'h00000000, ctrl_ff};
	wire logic [31:0] rd_word = hit_cfg ? cfg_word :
		hit_ctrl ? ctrl_word :
		hit_stat ? stat_word : 32'h00000000;
	// Captured at setup so the word stands through the access phase
	assign nxt_prdata = rd_setup ? rd_word : prdata_ff;
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			prdata_ff <= 32'h00000000;
		else
			prdata_ff <= nxt_prdata;
	end
	// Error raised at setup too, so it lines up with the access phase
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			pslverr_ff <= 1'b0;
		else
			pslverr_ff <= err_setup;
	end

	// ----------------------------------------
	// Loop state
	// ----------------------------------------
	// Sync and carrier sampled only at loop updates to keep gains stable
	wire logic carrier_ok = ~freeze_en | CARRIER_SENSE; // RULE_08
	wire logic go_freeze = ~carrier_ok;
	wire logic go_post = carrier_ok & SYNC_DETECTED;
	// Losing sync drops back to the pre-sync gains
	wire logic go_pre = carrier_ok & ~SYNC_DETECTED;
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			bsg_pkg::BSG_FROZEN: begin
				if (carrier_ok)
					nxt_state = bsg_pkg::BSG_PRE; // RULE_08
			end
			bsg_pkg::BSG_PRE: begin
				if (go_freeze)
					nxt_state = bsg_pkg::BSG_FROZEN; // RULE_08
				else if (go_post)
					nxt_state = bsg_pkg::BSG_POST;
			end
			bsg_pkg::BSG_POST: begin
				if (go_freeze)
					nxt_state = bsg_pkg::BSG_FROZEN;
				else if (go_pre)
					nxt_state = bsg_pkg::BSG_PRE;
			end
			default: begin
				nxt_state = bsg_pkg::BSG_FROZEN;
			end
		endcase
	end
	wire logic nxt_frozen = nxt_state == bsg_pkg::BSG_FROZEN;
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			state_ff <= bsg_pkg::BSG_FROZEN;
		else if (LOOP_UPDATE)
			state_ff <= nxt_state;
	end
	// Frozen flag in its own flop so the output leaves a register
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			frozen_ff <= 1'b1;
		else if (LOOP_UPDATE)
			frozen_ff <= nxt_frozen; // RULE_08
	end

	// ----------------------------------------
	// Gain selection
	// ----------------------------------------
	wire logic synced = state_ff == bsg_pkg::BSG_POST;
	wire logic running = state_ff != bsg_pkg::BSG_FROZEN;
	wire logic [3:0] ki_sel;
	wire logic [3:0] kp_sel;
	bsg_gain_sel #(.POST_VALUE(bsg_pkg::GAIN_HALF)) u_ki ( // RULE_03
		.pre_code(pre_ki), // RULE_01
		.post_bit(post_ki),
		.synced(synced),
		.gain(ki_sel)
	);
	bsg_gain_sel #(.POST_VALUE(bsg_pkg::GAIN_ONE)) u_kp ( // RULE_04
		.pre_code(pre_kp), // RULE_02
		.post_bit(post_kp),
		.synced(synced),
		.gain(kp_sel)
	);

	// ----------------------------------------
	// Rate offset accumulation
	// ----------------------------------------
	wire logic lim_off = lim_code == 2'h0;
	wire logic lim_small = lim_code == 2'h1;
	wire logic lim_mid = lim_code == 2'h2;
	wire logic [OFS_W-1:0] lim_val = lim_off ? bsg_pkg::LIM_NONE :
		lim_small ? bsg_pkg::LIM_3P125 :
		lim_mid ? bsg_pkg::LIM_6P25 : bsg_pkg::LIM_12P5; // RULE_07
	// Only the pre-sync integral gain trims rate; post-sync keeps estimate
	wire logic [4:0] ki_pre = {1'b0, pre_ki, 1'b0} + 5'h02;
	wire logic signed [5:0] ki_mul = $signed({1'b0, ki_pre});
	wire logic signed [OFS_W+5:0] step_w = RATE_ERROR * ki_mul;
	// Half-unit gain and a quarter loop scale: three bits are dropped
	wire logic signed [OFS_W+5:0] step_sh = step_w >>> 3;
	wire logic signed [OFS_W-1:0] step = OFS_W'(step_sh);
	wire logic signed [OFS_W:0] sum_w = ofs_ff + step;
	// Saturate rather than wrap, so a large error cannot flip the sign
	wire logic sum_sign = sum_w[OFS_W];
	wire logic sum_ovf = sum_sign != sum_w[OFS_W-1];
	wire logic signed [OFS_W-1:0] sum_sat = {sum_sign, {(OFS_W-1){~sum_sign}}};
	wire logic signed [OFS_W-1:0] sum = sum_ovf ? sum_sat : sum_w[OFS_W-1:0];
	wire logic in_pre = state_ff == bsg_pkg::BSG_PRE;
	wire logic track = LOOP_UPDATE & in_pre; // RULE_05
	wire logic signed [OFS_W-1:0] ofs_raw = track ? sum : ofs_ff;
	wire logic signed [OFS_W-1:0] ofs_clamped;
	bsg_rate_clamp #(.W(OFS_W)) u_clamp (
		.offset_in(ofs_raw),
		.limit(lim_val),
		.offset_out(ofs_clamped) // RULE_06
	);

	// ----------------------------------------
	// Loop update registers
	// ----------------------------------------
	// A frozen loop keeps its offset even if the limit is lowered meanwhile
	wire logic ofs_load = LOOP_UPDATE & running; // RULE_08
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			ki_ff <= bsg_pkg::GAIN_ONE;
		else if (LOOP_UPDATE)
			ki_ff <= ki_sel; // RULE_09
	end
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			kp_ff <= bsg_pkg::GAIN_ONE;
		else if (LOOP_UPDATE)
			kp_ff <= kp_sel;
	end
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			ofs_ff <= '0;
		else if (ofs_load)
			ofs_ff <= ofs_clamped;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign INTEGRAL_GAIN = ki_ff;
	assign PROPORTIONAL_GAIN = kp_ff;
	assign RATE_OFFSET = ofs_ff;
	assign LOOP_FROZEN = frozen_ff;
	assign PRDATA = prdata_ff;
	// No wait state is ever needed, so ready is a constant
	assign PREADY = 1'b1;
	assign PSLVERR = pslverr_ff;
endmodule

// file: inc/bsg_pkg.sv
// Purpose: Constants for the clock recovery loop gain configuration block
// Assumes: APB with 32-bit data, word aligned registers
// Notes: Gains are expressed in half units of the base gain
package bsg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] ADDR_CFG = 12'h000;
	localparam logic [11:0] ADDR_CTRL = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [7:0] CFG_RESET = 8'h6C;
	localparam logic [0:0] CTRL_RESET = 1'h1;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PRE_KI_LSB = 6;
	localparam int PRE_KP_LSB = 4;
	localparam int POST_KI_BIT = 3;
	localparam int POST_KP_BIT = 2;
	localparam int LIMIT_LSB = 0;
	localparam int FREEZE_BIT = 0;
	// ----------------------------------------
	// Gain and limit encodings
	// ----------------------------------------
	// Gain multipliers in units of half the base gain
	localparam logic [3:0] GAIN_HALF = 4'h1;
	localparam logic [3:0] GAIN_ONE = 4'h2;
	// Limits in units of 1/32 percent: 3.125, 6.25, 12.5 percent
	localparam logic [15:0] LIM_NONE = 16'h0000;
	localparam logic [15:0] LIM_3P125 = 16'h0064;
	localparam logic [15:0] LIM_6P25 = 16'h00C8;
	localparam logic [15:0] LIM_12P5 = 16'h0190;
	typedef enum logic [1:0] {
		BSG_FROZEN = 2'h0,
		BSG_PRE = 2'h1,
		BSG_POST = 2'h3
	} bsg_state_t;
endpackage

// file: verification/bsg_top_properties.sv
// Purpose: Port checks for the loop gain configuration block
// Assumes: Gains in half-base units, offset in 1/32 percent
// Notes: Bound into bsg_top below
`timescale 1ns/100ps
module bsg_top_properties #(
	parameter int OFS_W = 16
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic CARRIER_SENSE,
	input wire logic LOOP_UPDATE,
	input wire logic [3:0] INTEGRAL_GAIN,
	input wire logic [3:0] PROPORTIONAL_GAIN,
	input wire logic signed [OFS_W-1:0] RATE_OFFSET,
	input wire logic LOOP_FROZEN
);
	// ----------------------------------------
	// Freeze option shadow
	// ----------------------------------------
	// Follows the control bit from bus writes so the freeze check obeys it
	logic frz_en_ff;
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			frz_en_ff <= 1'b1;
		else if (PSEL && PENABLE && PWRITE && PSTRB[0] && PADDR == 12'h004)
			frz_en_ff <= PWDATA[0];
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	a_no_wait: assert property (PREADY)
		else $error("wait state seen");
	a_err_unmapped: assert property (
		PSEL && PENABLE && PADDR > 12'h008 |-> PSLVERR)
		else $error("no error on unmapped access");
	a_freeze_holds: assert property (
		frz_en_ff && LOOP_FROZEN && !CARRIER_SENSE |=> LOOP_FROZEN)
		else $error("loop left freeze without carrier");
	a_frozen_ofs: assert property (
		LOOP_FROZEN |=> $stable(RATE_OFFSET))
		else $error("offset moved while frozen");
	a_ofs_on_tick: assert property (
		!LOOP_UPDATE |=> $stable(RATE_OFFSET))
		else $error("offset moved without loop tick");
	a_gain_on_tick: assert property (
		!LOOP_UPDATE |=> $stable({INTEGRAL_GAIN, PROPORTIONAL_GAIN}))
		else $error("gain moved without loop tick");
	a_ki_legal: assert property (
		INTEGRAL_GAIN inside {1, 2, 4, 6, 8})
		else $error("illegal integral gain");
	a_kp_legal: assert property (
		PROPORTIONAL_GAIN inside {2, 4, 6, 8})
		else $error("illegal proportional gain");
	a_ofs_bound: assert property (
		RATE_OFFSET >= -400 && RATE_OFFSET <= 400)
		else $error("offset beyond widest limit");
	c_unfreeze: cover property ($fell(LOOP_FROZEN));
	c_slverr: cover property (PSLVERR);
	c_ofs_max: cover property (RATE_OFFSET == 400);
endmodule
bind bsg_top bsg_top_properties #(.OFS_W(OFS_W)) u_props (
	.CLK_SYS(CLK_SYS),
	.RESET(RESET),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PWDATA(PWDATA),
	.PSTRB(PSTRB),
	.PREADY(PREADY),
	.PSLVERR(PSLVERR),
	.CARRIER_SENSE(CARRIER_SENSE),
	.LOOP_UPDATE(LOOP_UPDATE),
	.INTEGRAL_GAIN(INTEGRAL_GAIN),
	.PROPORTIONAL_GAIN(PROPORTIONAL_GAIN),
	.RATE_OFFSET(RATE_OFFSET),
	.LOOP_FROZEN(LOOP_FROZEN)
);

// file: verification/bsg_top_tb.sv
// Purpose: Self-checking bench for the loop gain configuration block
// Assumes: Zero wait state APB, gains settle within two loop ticks
// Notes: Large rate errors saturate the offset in one tick
`timescale 1ns/100ps
module bsg_top_tb;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sync = 0, cs = 0;
	logic upd = 0, rdy, serr, frz, e, s;
	logic [11:0] addr = 0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] wd = 0, rd, r;
	logic [7:0] c;
	logic [3:0] ig, pg;
	logic signed [15:0] rerr = 0, ofs, x;
	logic [15:0] lim [4] = '{16'h0000, 16'h0064, 16'h00C8, 16'h0190};
	int err_count = 0, n_checks = 0, cyc = 0;
	always #5 clk = ~clk;
	bsg_top DUT (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(addr), .PWDATA(wd), .PSTRB(pstrb), .PRDATA(rd),
		.PREADY(rdy), .PSLVERR(serr), .SYNC_DETECTED(sync),
		.CARRIER_SENSE(cs), .LOOP_UPDATE(upd), .RATE_ERROR(rerr),
		.INTEGRAL_GAIN(ig), .PROPORTIONAL_GAIN(pg), .RATE_OFFSET(ofs),
		.LOOP_FROZEN(frz));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] t);
		n_checks++;
		if (g !== t) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, t);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (rdy !== 1'b1);
		r = rd;
		e = serr;
		psel <= 0;
		pen <= 0;
	endtask
	// Whole ticks only; checks follow once the tick edge has landed
	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			upd <= 1;
			@(posedge clk);
			upd <= 0;
		end
		#1;
	endtask
	function logic [3:0] xki(input logic [7:0] v, input logic y);
		return (y && v[3]) ? 4'h1 : 4'h2 + {1'b0, v[7:6], 1'b0};
	endfunction
	function logic [3:0] xkp(input logic [7:0] v, input logic y);
		return (y && v[2]) ? 4'h2 : 4'h2 + {1'b0, v[5:4], 1'b0};
	endfunction
	task wrap_up;
		$display("mismatches %0d checks %0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up;
		end
	end
	initial begin
		void'($urandom(52851));
		repeat (10) @(posedge clk);
		rst <= 0;
		apb(0, 12'h000, 0);
		chk(r, 32'h6C);
		apb(0, 12'h004, 0);
		chk(r, 32'h1);
		apb(1, 12'h00C, 32'hFF);
		apb(0, 12'h00C, 0);
		chk({r[31:1], e}, 32'h1);
		@(posedge clk);
		pstrb <= 4'hE;
		apb(1, 12'h000, 32'h00);
		pstrb <= 4'hF;
		apb(0, 12'h000, 0);
		chk(r, 32'h6C);
		tick(2);
		chk(frz, 1);
		@(posedge clk);
		cs <= 1;
		tick(2);
		chk(frz, 0);
		for (int i = 0; i < 16; i++) begin
			c = {i[1:0], i[3:2], 2'($urandom), 2'h1};
			s = 1'($urandom);
			@(posedge clk);
			sync <= s;
			apb(1, 12'h000, {24'h0, c});
			tick(2);
			chk(ig, xki(c, s));
			chk(pg, xkp(c, s));
			apb(0, 12'h000, 0);
			chk(r, {24'h0, c});
		end
		@(posedge clk);
		sync <= 0;
		for (int k = 0; k < 8; k++) begin
			x = k[2] ? -lim[k[1:0]] : lim[k[1:0]];
			@(posedge clk);
			rerr <= (k[2] ? -16'sd1 : 16'sd1) * 16'($urandom_range(32767, 16384));
			apb(1, 12'h000, {24'h0, 6'($urandom), k[1:0]});
			tick(3);
			chk(ofs, x);
			apb(0, 12'h008, 0);
			chk(r[15:0], x[15:0]);
		end
		@(posedge clk);
		sync <= 1;
		tick(3);
		chk(ofs, x);
		apb(1, 12'h004, 0);
		apb(0, 12'h004, 0);
		chk(r, 32'h0);
		@(posedge clk);
		cs <= 0;
		tick(2);
		chk(frz, 0);
		wrap_up;
	end
endmodule
